// ==== pmic_gpio_function_mux.sv ====
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module pmic_gpio_function_mux (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire pin_mux_pkg::reg_req_s req,
  output logic [31:0] rdata,
  // Muxed pins gpio2..gpio8
  input wire logic [6:0] pin_in,
  output logic [6:0] pin_out,
  output logic [6:0] pin_oe,
  // Strap and sequencer inputs
  input wire logic gpio3_strap_high,
  input wire logic lockout_release,
  input wire logic reg_two_ramp_start,
  input wire logic rails_power_good,
  input wire logic power_bad_unmasked,
  input wire logic in_err_flag,
  input wire logic out_err_flag,
  input wire logic supply_above_mon,
  // Controls to power logic
  output logic power_good_reset_out,
  output logic linear_reg_two_ldo_mode,
  output logic sleep_state_first,
  output logic sleep_state_second,
  output logic buck_rails_one_two_en,
  output logic power_disable_in,
  output logic ext_enable_out_1,
  output logic ext_enable_out_2,
  output logic irq
);

  localparam int NP = 7;

  // Synchronised pins
  logic [NP-1:0] s1_q, s2_q, s3_q, pin_q;
  logic [NP-1:0][3:0] code_q;
  logic [NP-1:0] ovr_q;
  logic [NP-1:0][3:0] code_eff;
  localparam int IRQ_W_L = pin_mux_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] stat_q, mask_q;
  logic [15:0] delay_q;
  logic [15:0] cnt1_q, cnt2_q;
  logic trig1, trig2;
  logic strap_done_q, ldo_mode_q, gpio5_def_q, lockout_seen_q;
  logic pg_q;
  logic bad_code;
  logic [31:0] rdata_d;

  function automatic logic trig_ok(input int idx);
    // GPIO2/3/4 cannot hold trigger codes
    return idx > 2;
  endfunction : trig_ok

  function automatic logic code_legal(input int idx, input logic [3:0] c);
    if (c > pin_mux_pkg::FN_SUPPLY_MON) begin
      return 1'b0;
    end
    if ((c == pin_mux_pkg::FN_EXT_TRIG_1 || c == pin_mux_pkg::FN_EXT_TRIG_2) && !trig_ok(idx)) begin
      return 1'b0;
    end
    if (c == pin_mux_pkg::FN_SUPPLY_MON && idx != 3) begin
      return 1'b0;
    end
    return 1'b1;
  endfunction : code_legal

  function automatic logic is_input(input logic [3:0] c);
    return c inside {pin_mux_pkg::FN_SLEEP_1, pin_mux_pkg::FN_SLEEP_2,
      pin_mux_pkg::FN_BUCK_EN, pin_mux_pkg::FN_PWR_DIS,
      pin_mux_pkg::FN_EXT_TRIG_1, pin_mux_pkg::FN_EXT_TRIG_2};
  endfunction : is_input

  // Three-stage pin synchronisers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pin_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NP; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          pin_q[i] <= s3_q[i];
        end
      end
    end
  end

  // Power-good reset output
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pg_q <= 1'b0;
    end else begin
      pg_q <= rails_power_good && !power_bad_unmasked;
    end
  end
  assign power_good_reset_out = pg_q;

  // Straps: GPIO3 at lockout release, GPIO6 at ramp start
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lockout_seen_q <= 1'b0;
      gpio5_def_q <= 1'b0;
      strap_done_q <= 1'b0;
      ldo_mode_q <= 1'b1;
    end else begin
      if (lockout_release && !lockout_seen_q) begin
        lockout_seen_q <= 1'b1;
        gpio5_def_q <= gpio3_strap_high;
      end
      if (reg_two_ramp_start && !strap_done_q && !pg_q) begin
        strap_done_q <= 1'b1;
        ldo_mode_q <= pin_q[4];
      end
    end
  end
  assign linear_reg_two_ldo_mode = ldo_mode_q;

  // Function registers, writes refused when code is illegal for the pin
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= '0;
      ovr_q <= '0;
    end else if (req.wr && req.addr <= pin_mux_pkg::REG_FUNC_8 && req.addr[1:0] == 2'b00) begin
      for (int i = 0; i < NP; i++) begin
        if (req.addr[7:2] == 6'(i)
            && code_legal(i, req.wdata[pin_mux_pkg::FLD_CODE_LSB +: 4])) begin
          code_q[i] <= req.wdata[pin_mux_pkg::FLD_CODE_LSB +: 4];
          ovr_q[i] <= req.wdata[pin_mux_pkg::FLD_EN_BIT];
        end
      end
    end
  end

  always_comb begin
    bad_code = 1'b0;
    if (req.wr && req.addr <= pin_mux_pkg::REG_FUNC_8 && req.addr[1:0] == 2'b00) begin
      bad_code = !code_legal(int'(req.addr[7:2]), req.wdata[pin_mux_pkg::FLD_CODE_LSB +: 4]);
    end
  end

  // Effective function code of each pin
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      if (i == 3) begin
        code_eff[i] = (pg_q && ovr_q[i]) ? code_q[i]
                    : (gpio5_def_q ? pin_mux_pkg::FN_SLEEP_1 : pin_mux_pkg::FN_IRQ);
      end else if (i == 5) begin
        code_eff[i] = (pg_q && ovr_q[i]) ? code_q[i] : pin_mux_pkg::DEF_GPIO7;
      end else if (i == 6) begin
        code_eff[i] = (pg_q && ovr_q[i]) ? code_q[i] : pin_mux_pkg::DEF_GPIO8;
      end else begin
        // Override only after power-good and while enabled
        code_eff[i] = (pg_q && ovr_q[i]) ? code_q[i] : pin_mux_pkg::DEF_GPIO_2346;
      end
    end
  end

  // Gather input functions; last matching pin wins
  always_comb begin
    sleep_state_first = 1'b0;
    sleep_state_second = 1'b0;
    buck_rails_one_two_en = 1'b1;
    power_disable_in = 1'b0;
    trig1 = 1'b0;
    trig2 = 1'b0;
    for (int i = 0; i < NP; i++) begin
      unique case (code_eff[i])
        pin_mux_pkg::FN_SLEEP_1: sleep_state_first = !pin_q[i];
        pin_mux_pkg::FN_SLEEP_2: sleep_state_second = !pin_q[i];
        pin_mux_pkg::FN_BUCK_EN: buck_rails_one_two_en = pin_q[i];
        pin_mux_pkg::FN_PWR_DIS: power_disable_in = pin_q[i];
        pin_mux_pkg::FN_EXT_TRIG_1: trig1 = pin_q[i];
        pin_mux_pkg::FN_EXT_TRIG_2: trig2 = pin_q[i];
        default: ;
      endcase
    end
    if (sleep_state_first || sleep_state_second) begin
      buck_rails_one_two_en = 1'b0;
    end
  end

  // External enable delay counters
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt1_q <= '0;
      cnt2_q <= '0;
      ext_enable_out_1 <= 1'b0;
      ext_enable_out_2 <= 1'b0;
    end else begin
      if (trig1 && !ext_enable_out_1) begin
        cnt1_q <= cnt1_q + 16'h0001;
        if (cnt1_q >= delay_q) begin
          ext_enable_out_1 <= 1'b1;
        end
      end
      if (trig2 && !ext_enable_out_2) begin
        cnt2_q <= cnt2_q + 16'h0001;
        if (cnt2_q >= delay_q) begin
          ext_enable_out_2 <= 1'b1;
        end
      end
    end
  end

  // Interrupt status, mask and delay
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= '0;
      mask_q <= pin_mux_pkg::RST_IRQ_MASK;
      delay_q <= pin_mux_pkg::RST_EXT_DELAY;
    end else begin
      if (req.wr && req.addr == pin_mux_pkg::REG_IRQ_MASK) begin
        mask_q <= req.wdata[IRQ_W_L-1:0];
      end
      if (req.wr && req.addr == pin_mux_pkg::REG_EXT_DELAY) begin
        delay_q <= req.wdata[15:0];
      end
      // Set wins over write-one-to-clear
      stat_q <= (stat_q & ~((req.wr && req.addr == pin_mux_pkg::REG_IRQ_STAT)
                 ? req.wdata[IRQ_W_L-1:0] : '0))
                | {bad_code, out_err_flag, in_err_flag};
    end
  end
  assign irq = |(stat_q & ~mask_q);

  // Pin drivers
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      pin_oe[i] = !is_input(code_eff[i]);
      if (i == 4 && !pg_q) begin
        // GPIO6 is a strap input until power-good
        pin_oe[i] = 1'b0;
      end
      unique case (code_eff[i])
        pin_mux_pkg::FN_EXT_OUT_1: pin_out[i] = ext_enable_out_1;
        pin_mux_pkg::FN_EXT_OUT_2: pin_out[i] = ext_enable_out_2;
        pin_mux_pkg::FN_IRQ: pin_out[i] = !(|(stat_q[1:0] & ~mask_q[1:0]));
        pin_mux_pkg::FN_SUPPLY_MON: pin_out[i] = supply_above_mon;
        default: pin_out[i] = 1'b0;
      endcase
    end
  end

  // Register read
  always_comb begin
    rdata_d = '0;
    if (req.rd) begin
      if (req.addr <= pin_mux_pkg::REG_FUNC_8 && req.addr[1:0] == 2'b00) begin
        rdata_d[3:0] = code_eff[req.addr[4:2]];
        rdata_d[pin_mux_pkg::FLD_EN_BIT] = ovr_q[req.addr[4:2]];
      end else if (req.addr == pin_mux_pkg::REG_STATUS) begin
        rdata_d[6:0] = pin_q;
        rdata_d[7] = pg_q;
        rdata_d[8] = ldo_mode_q;
        rdata_d[9] = ext_enable_out_1;
        rdata_d[10] = ext_enable_out_2;
      end else if (req.addr == pin_mux_pkg::REG_IRQ_STAT) begin
        rdata_d[IRQ_W_L-1:0] = stat_q;
      end else if (req.addr == pin_mux_pkg::REG_IRQ_MASK) begin
        rdata_d[IRQ_W_L-1:0] = mask_q;
      end else if (req.addr == pin_mux_pkg::REG_EXT_DELAY) begin
        rdata_d[15:0] = delay_q;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= rdata_d;
    end
  end

endmodule : pmic_gpio_function_mux

// ==== pin_mux_pkg.sv ====
package pin_mux_pkg;

  // Function codes
  localparam logic [3:0] FN_EXT_OUT_1 = 4'h0;
  localparam logic [3:0] FN_EXT_OUT_2 = 4'h1;
  localparam logic [3:0] FN_IRQ = 4'h2;
  localparam logic [3:0] FN_SLEEP_1 = 4'h3;
  localparam logic [3:0] FN_SLEEP_2 = 4'h4;
  localparam logic [3:0] FN_BUCK_EN = 4'h5;
  localparam logic [3:0] FN_PWR_DIS = 4'h6;
  localparam logic [3:0] FN_EXT_TRIG_1 = 4'h7;
  localparam logic [3:0] FN_EXT_TRIG_2 = 4'h8;
  localparam logic [3:0] FN_SUPPLY_MON = 4'h9;

  // Built-in defaults
  localparam logic [3:0] DEF_GPIO_2346 = 4'h0;
  localparam logic [3:0] DEF_GPIO7 = 4'h6;
  localparam logic [3:0] DEF_GPIO8 = 4'h4;

  // Register offsets
  localparam logic [7:0] REG_FUNC_2 = 8'h00;
  localparam logic [7:0] REG_FUNC_3 = 8'h04;
  localparam logic [7:0] REG_FUNC_4 = 8'h08;
  localparam logic [7:0] REG_FUNC_5 = 8'h0c;
  localparam logic [7:0] REG_FUNC_6 = 8'h10;
  localparam logic [7:0] REG_FUNC_7 = 8'h14;
  localparam logic [7:0] REG_FUNC_8 = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h20;
  localparam logic [7:0] REG_IRQ_MASK = 8'h24;
  localparam logic [7:0] REG_EXT_DELAY = 8'h28;

  // Function register fields
  localparam int FLD_CODE_LSB = 0;
  localparam int FLD_EN_BIT = 4;

  // Interrupt status bits
  localparam int IRQ_IN_ERR = 0;
  localparam int IRQ_OUT_ERR = 1;
  localparam int IRQ_BAD_CODE = 2;
  localparam int IRQ_W = 3;

  // Reset values
  localparam logic [15:0] RST_EXT_DELAY = 16'h0010;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 3'h0;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // Seven muxed pins: index 0..6 = gpio2,3,4,5,6,7,8
  typedef struct packed {
    logic [6:0] in;
    logic [6:0] out;
    logic [6:0] oe;
  } pin_grp_s;

endpackage : pin_mux_pkg

// ==== mux_chk.sv ====
`timescale 1ns/1ps
module mux_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Watched signals
  input wire logic [6:0] pin_in,
  input wire logic reg_two_ramp_start,
  input wire logic power_bad_unmasked,
  input wire logic power_good_reset_out,
  input wire logic linear_reg_two_ldo_mode,
  input wire logic sleep_state_first,
  input wire logic sleep_state_second,
  input wire logic buck_rails_one_two_en,
  input wire logic power_disable_in,
  input wire logic ext_enable_out_1,
  input wire logic ext_enable_out_2
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sleep_prio_a: assert property ((sleep_state_first || sleep_state_second) |->
    !buck_rails_one_two_en) else $error("buck on in sleep");
  strap_time_a: assert property ($changed(linear_reg_two_ldo_mode) |->
    $past(reg_two_ramp_start) && !$past(power_good_reset_out)) else $error("strap time");
  ldo_frozen_a: assert property (power_good_reset_out |->
    $stable(linear_reg_two_ldo_mode)) else $error("mode moved");
  pwr_dis_a: assert property ((!power_good_reset_out && pin_in[5]) [*6] |->
    power_disable_in) else $error("no power disable");
  sleep_two_a: assert property ((!power_good_reset_out && !pin_in[6]) [*6] |->
    sleep_state_second) else $error("no sleep two");
  ext_sticky_a: assert property (!($fell(ext_enable_out_1) ||
    $fell(ext_enable_out_2))) else $error("ext enable fell");
  bad_drop_a: assert property (power_bad_unmasked |=>
    !power_good_reset_out) else $error("pg kept");
  good_rise_a: assert property ($rose(power_good_reset_out) |->
    !$past(power_bad_unmasked)) else $error("pg rose on bad");
endmodule : mux_chk
bind pmic_gpio_function_mux mux_chk i_mux_chk (.mclk(mclk), .rst_n(rst_n), .pin_in(pin_in),
  .reg_two_ramp_start(reg_two_ramp_start), .power_bad_unmasked(power_bad_unmasked),
  .power_good_reset_out(power_good_reset_out), .linear_reg_two_ldo_mode(linear_reg_two_ldo_mode),
  .sleep_state_first(sleep_state_first), .sleep_state_second(sleep_state_second),
  .buck_rails_one_two_en(buck_rails_one_two_en), .power_disable_in(power_disable_in),
  .ext_enable_out_1(ext_enable_out_1), .ext_enable_out_2(ext_enable_out_2));

// ==== ssd_ctrl_model.sv ====
`timescale 1ns/1ps
module ssd_ctrl_model (
  // Design pin drive
  input wire logic [6:0] pin_out,
  input wire logic [6:0] pin_oe,
  // Controller drive
  input wire logic [6:0] ctl_drv,
  // Resolved level
  output logic [6:0] pin_in
);
  // Driven pins read back, others carry the sleep and trigger levels
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ctl_drv);
endmodule : ssd_ctrl_model

// ==== pmic_gpio_function_mux_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module pmic_gpio_function_mux_tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  pin_mux_pkg::reg_req_s req = '0;
  logic [31:0] rdata, rv;
  logic [6:0] pin_in, pin_out, pin_oe;
  logic [6:0] drv = 7'h48;
  logic strap = 1'b1, lrel = 1'b0, ramp = 1'b0, rpg = 1'b0, pbad = 1'b0;
  logic ierr = 1'b0, oerr = 1'b0, smon = 1'b0;
  logic pg, ldo, s1, s2, buck, pdis, e1, e2, irq;
  int errors = 0;
  int comparisons = 0;
  always #2 mclk = ~mclk;
  pmic_gpio_function_mux i_pmic_gpio_function_mux (.mclk(mclk), .rst_n(rst_n), .req(req),
    .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .gpio3_strap_high(strap), .lockout_release(lrel), .reg_two_ramp_start(ramp),
    .rails_power_good(rpg), .power_bad_unmasked(pbad), .in_err_flag(ierr),
    .out_err_flag(oerr), .supply_above_mon(smon), .power_good_reset_out(pg),
    .linear_reg_two_ldo_mode(ldo), .sleep_state_first(s1), .sleep_state_second(s2),
    .buck_rails_one_two_en(buck), .power_disable_in(pdis), .ext_enable_out_1(e1),
    .ext_enable_out_2(e2), .irq(irq));
  ssd_ctrl_model i_ssd_ctrl_model (.pin_out(pin_out), .pin_oe(pin_oe), .ctl_drv(drv),
    .pin_in(pin_in));
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge mclk);
    req.wr <= 1'b0;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 rv = rdata;
    cyc(1);
  endtask : rd
  task automatic t_boot();
    `CHK("ldo", 1'b1, ldo)
    rd(pin_mux_pkg::REG_EXT_DELAY);
    `CHK("dly", 32'h10, rv)
    rd(8'h80);
    `CHK("unmapped", 32'h0, rv)
    lrel <= 1'b1;
    ramp <= 1'b1;
    cyc(1);
    ramp <= 1'b0;
    cyc(2);
    `CHK("ldo", 1'b0, ldo)
    rd(pin_mux_pkg::REG_FUNC_5);
    `CHK("f5", 4'h3, rv[3:0])
    rd(pin_mux_pkg::REG_FUNC_7);
    `CHK("f7", 4'h6, rv[3:0])
    rd(pin_mux_pkg::REG_FUNC_8);
    `CHK("f8", 4'h4, rv[3:0])
    drv <= 7'h20;
    cyc(6);
    `CHK("asleep", 5'b11100, {s1, s2, pdis, buck, pin_oe[3]})
    drv <= 7'h48;
    cyc(6);
    `CHK("awake", 4'b0001, {s1, s2, pdis, buck})
  endtask : t_boot
  task automatic t_pg();
    rpg <= 1'b1;
    drv[4] <= 1'b1;
    cyc(5);
    `CHK("pg", 1'b1, pg)
    ramp <= 1'b1;
    cyc(1);
    ramp <= 1'b0;
    cyc(3);
    `CHK("ldo", 1'b0, ldo)
    pbad <= 1'b1;
    cyc(2);
    `CHK("pbad", 1'b0, pg)
    pbad <= 1'b0;
    cyc(3);
    `CHK("pg", 1'b1, pg)
  endtask : t_pg
  task automatic t_refuse();
    wr(pin_mux_pkg::REG_FUNC_2, 32'h17);
    rd(pin_mux_pkg::REG_FUNC_2);
    `CHK("f2", 4'h0, rv[3:0])
    rd(pin_mux_pkg::REG_IRQ_STAT);
    `CHK("stat", 4'h9, {rv[2:0], irq})
    wr(pin_mux_pkg::REG_IRQ_STAT, 32'h4);
    wr(pin_mux_pkg::REG_FUNC_6, 32'h19);
    rd(pin_mux_pkg::REG_IRQ_STAT);
    `CHK("f6", 3'h4, rv[2:0])
    wr(pin_mux_pkg::REG_IRQ_STAT, 32'h4);
    wr(pin_mux_pkg::REG_FUNC_5, 32'h19);
    smon <= 1'b1;
    cyc(5);
    `CHK("mon", 3'b110, {pin_oe[3], pin_out[3], irq})
    smon <= 1'b0;
    cyc(5);
    `CHK("mon", 1'b0, pin_out[3])
  endtask : t_refuse
  task automatic t_ext();
    wr(pin_mux_pkg::REG_EXT_DELAY, 32'h2);
    wr(pin_mux_pkg::REG_FUNC_2, 32'h10);
    wr(pin_mux_pkg::REG_FUNC_6, 32'h17);
    wr(pin_mux_pkg::REG_FUNC_7, 32'h18);
    drv <= 7'h78;
    cyc(12);
    `CHK("ext", 4'b1111, {e1, e2, pin_out[0], pin_oe[0]})
    wr(pin_mux_pkg::REG_FUNC_6, 32'h07);
    rd(pin_mux_pkg::REG_FUNC_6);
    `CHK("f6", 4'h0, rv[3:0])
  endtask : t_ext
  task automatic t_irq();
    wr(pin_mux_pkg::REG_IRQ_MASK, 32'h1);
    ierr <= 1'b1;
    cyc(1);
    ierr <= 1'b0;
    cyc(4);
    `CHK("masked", 1'b0, irq)
    wr(pin_mux_pkg::REG_IRQ_MASK, 32'h0);
    wr(pin_mux_pkg::REG_FUNC_5, 32'h12);
    `CHK("irqpin", 3'b110, {irq, pin_oe[3], pin_out[3]})
    wr(pin_mux_pkg::REG_IRQ_STAT, 32'h1);
    oerr <= 1'b1;
    cyc(1);
    oerr <= 1'b0;
    cyc(4);
    `CHK("oerr", 1'b1, irq)
    wr(pin_mux_pkg::REG_IRQ_STAT, 32'h2);
    `CHK("clear", 2'b01, {irq, pin_out[3]})
  endtask : t_irq
  task automatic t_strap();
    rpg <= 1'b0;
    rst_n <= 1'b0;
    drv <= 7'h58;
    cyc(2);
    rst_n <= 1'b1;
    cyc(6);
    ramp <= 1'b1;
    cyc(1);
    ramp <= 1'b0;
    cyc(2);
    `CHK("ldo_hi", 1'b1, ldo)
    rd(pin_mux_pkg::REG_STATUS);
    `CHK("strap_st", 3'b110, {rv[8], rv[4], rv[7]})
  endtask : t_strap
  task automatic complete_run();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  initial begin
    #40000;
    errors++;
    complete_run();
  end
  initial begin
    cyc(5);
    rst_n <= 1'b1;
    cyc(1);
    t_boot();
    t_pg();
    t_refuse();
    t_ext();
    t_irq();
    t_strap();
    complete_run();
  end
endmodule : pmic_gpio_function_mux_tb_top
